/* retry_card_pkg.sv */
// constants and carrier types for the retry and card control block
package retry_card_pkg;

   // configuration offsets
   localparam logic [7:0] RETRY_STATUS_OFFSET    = 8'h90;
   localparam logic [7:0] CARD_CONTROL_OFFSET    = 8'h91;
   localparam logic [7:0] PIN_ROUTE_LOW_OFFSET   = 8'h8C;

   // retry_timeout_status fields
   localparam int HOST_TIMER_EN_BIT = 7;
   localparam int CARD_TIMER_EN_BIT = 6;
   localparam int CARD_B_EXP_BIT    = 5;
   localparam int CARD_A_EXP_BIT    = 3;
   localparam int HOST_EXP_BIT      = 1;

   // socket_card_control fields
   localparam int RING_EN_BIT  = 7;
   localparam int VIDEO_EN_BIT = 6;
   localparam int PORT_SEL_BIT = 5;
   localparam int AUDIO_EN_BIT = 2;
   localparam int SPK_EN_BIT   = 1;
   localparam int INT_FLAG_BIT = 0;

   // values after reset
   localparam logic       HOST_TIMER_EN_RESET = 1'b1;
   localparam logic       CARD_TIMER_EN_RESET = 1'b1;
   localparam logic [7:0] PIN_ROUTE_RESET     = 8'h00;
   localparam logic [7:0] CFG_DATA_RESET      = 8'h00;

   // retry wait, in PCI clocks (two to the power 15)
   localparam int unsigned RETRY_WAIT_CLOCKS = 32768;
   localparam int          RETRY_COUNT_W     = 16;

   // multipurpose pin 0 routing codes
   localparam logic [3:0] ROUTE_GENERAL_INPUT  = 4'h0;
   localparam logic [3:0] ROUTE_GENERAL_OUTPUT = 4'h1;
   localparam logic [3:0] ROUTE_HOST_INT_A     = 4'h2;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       func;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } cfg_rsp_t;

   typedef enum logic [1:0] {
      TIMER_IDLE = 2'b01,
      TIMER_WAIT = 2'b10
   } timer_state_t;

endpackage

/* retry_wait_timer.sv */
// retry wait timer: one per retried master side
`timescale 1ns/1ps
module retry_wait_timer #(
   parameter int unsigned LIMIT = retry_card_pkg::RETRY_WAIT_CLOCKS
) (
   input  wire logic clk_in,
   input  wire logic rstn_in,
   input  wire logic ce_in,
   input  wire logic enable_in,
   input  wire logic retry_in,
   input  wire logic return_in,
   output logic      expired_out
);
   import retry_card_pkg::*;

   timer_state_t             state;
   timer_state_t             next_state;
   logic [RETRY_COUNT_W-1:0] count;
   logic [RETRY_COUNT_W-1:0] next_count;
   logic                     next_expired;

   always_comb begin
      next_state   = state;
      next_count   = count;
      next_expired = 1'b0;
      if (!enable_in) begin
         next_state = TIMER_IDLE;
         next_count = '0;
      end else begin
         case (state)
            TIMER_IDLE: begin
               if (retry_in) begin
                  next_state = TIMER_WAIT;
                  next_count = '0;
               end
            end
            TIMER_WAIT: begin
               if (return_in) begin
                  next_state = TIMER_IDLE;
                  next_count = '0;
               end else if (count == RETRY_COUNT_W'(LIMIT - 1)) begin
                  next_expired = 1'b1;
                  next_state   = TIMER_IDLE;
                  next_count   = '0;
               end else begin
                  next_count = count + 16'h0001;
               end
            end
            default: begin
               next_state = TIMER_IDLE;
               next_count = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state       <= TIMER_IDLE;
         count       <= '0;
         expired_out <= 1'b0;
      end else if (ce_in) begin
         state       <= next_state;
         count       <= next_count;
         expired_out <= next_expired;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   a_timer_disabled_quiet: assert property (
      ce_in && !enable_in |=> !expired_out && state == TIMER_IDLE)
      else $error("retry timer ran while disabled");

   a_timer_expire_limit: assert property (
      ce_in && enable_in && !return_in && state == TIMER_WAIT
      && count == RETRY_COUNT_W'(LIMIT - 1) |=> expired_out)
      else $error("retry timer missed its limit");

   a_timer_return_stops: assert property (
      ce_in && enable_in && return_in && state == TIMER_WAIT
      |=> !expired_out && count == '0)
      else $error("retry timer kept counting after return");

endmodule

/* retry_card_control.sv */
// retry timeout status, socket card control and low pin routing registers
//
// Function
// - time retried master, flag after 2^15 clocks
// - expiry flags clear only on written one
// - bit 7 enables host retry timer
// - bit 6 enables card retry timer, global
// - bit 5 flags socket B card expiry
// - bit 3 flags socket A card expiry
// - bit 1 flags host side expiry
// - reserved bits read as zero
// - ring enable gates all ring output routing
// - video enable floats socket video pins
// - port select picks video winner
// - audio enable routes card audio to pwm
// - both audio enabled, socket 0 wins
// - speaker pin is XOR of sockets
// - speaker pin driven only when enabled
// - card interrupt sets per-socket flag
// - writing one clears interrupt flag
// - low field selects pin 0 source
// - serial strap gives pin 1 serial data
`timescale 1ns/1ps
module retry_card_control #(
   parameter int unsigned RETRY_LIMIT = retry_card_pkg::RETRY_WAIT_CLOCKS
) (
   input  wire logic                     CORE_CLK_IN,
   input  wire logic                     RSTN_IN,
   input  wire logic                     CORE_CE_IN,
   input  wire retry_card_pkg::cfg_req_t CFG_REQ_IN,
   output retry_card_pkg::cfg_rsp_t      CFG_RSP_OUT,
   input  wire logic                     HOST_RETRY_IN,
   input  wire logic                     HOST_RETURN_IN,
   input  wire logic [1:0]               CARD_RETRY_IN,
   input  wire logic [1:0]               CARD_RETURN_IN,
   input  wire logic [1:0]               CARD_FUNC_INT_IN,
   input  wire logic                     RING_INDICATE_OUTPUT_IN,
   input  wire logic                     RING_PIN_SELECT_IN,
   output logic                          RING_PIN_OUT,
   output logic                          RING_ROUTE_OUT,
   output logic [1:0]                    VIDEO_PORT_HIZ_OUT,
   output logic                          VIDEO_SELECT_SOCKET0_OUT,
   output logic                          VIDEO_SELECT_SOCKET1_OUT,
   input  wire logic [1:0]               CARD_AUDIO_SIGNAL_IN,
   output logic                          AUDIO_PWM_OUTPUT_OUT,
   input  wire logic [1:0]               CARD_SPEAKER_SIGNAL_IN,
   output logic                          SPEAKER_OUTPUT_PIN_OUT,
   output logic                          SPEAKER_OUTPUT_PIN_OE_OUT,
   input  wire logic                     GENERAL_OUTPUT_0_IN,
   input  wire logic                     HOST_INTERRUPT_A_IN,
   output logic                          GENERAL_INPUT_0_OUT,
   input  wire logic                     MULTIPURPOSE_PIN_0_IN,
   output logic                          MULTIPURPOSE_PIN_0_OUT,
   output logic                          MULTIPURPOSE_PIN_0_OE_OUT,
   input  wire logic                     SERIAL_LATCH_N_IN,
   input  wire logic                     SERIAL_DATA_LOW_IN,
   output logic                          MULTIPURPOSE_PIN_1_OUT,
   output logic                          MULTIPURPOSE_PIN_1_OE_OUT,
   output logic                          SERIAL_MODE_OUT
);
   import retry_card_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // register state
   logic       host_timer_en, next_host_timer_en;
   logic       card_timer_en, next_card_timer_en;
   logic       host_exp, next_host_exp;
   logic       card_a_exp, next_card_a_exp;
   logic       card_b_exp, next_card_b_exp;
   logic       ring_en, next_ring_en;
   logic [1:0] video_en, next_video_en;
   logic [1:0] port_sel, next_port_sel;
   logic [1:0] audio_en, next_audio_en;
   logic [1:0] spk_en, next_spk_en;
   logic [1:0] int_flag, next_int_flag;
   logic [7:0] route, next_route;
   logic       strap_done, next_strap_done;
   logic       next_serial_mode;
   cfg_rsp_t   next_rsp;
   logic       host_expire;
   logic [1:0] card_expire;
   logic       wr_retry;
   logic       wr_card;
   logic       f;

   ////////////////////////////////////////////////////////////////////////////////
   // retry timers: socket A is function 0, socket B function 1
   retry_wait_timer #(.LIMIT(RETRY_LIMIT)) u_host_timer (
      .clk_in      (CORE_CLK_IN),
      .rstn_in     (RSTN_IN),
      .ce_in       (CORE_CE_IN),
      .enable_in   (host_timer_en),
      .retry_in    (HOST_RETRY_IN),
      .return_in   (HOST_RETURN_IN),
      .expired_out (host_expire)
   );

   for (genvar s = 0; s < 2; s++) begin : g_card_timer
      retry_wait_timer #(.LIMIT(RETRY_LIMIT)) u_card_timer (
         .clk_in      (CORE_CLK_IN),
         .rstn_in     (RSTN_IN),
         .ce_in       (CORE_CE_IN),
         .enable_in   (card_timer_en),
         .retry_in    (CARD_RETRY_IN[s]),
         .return_in   (CARD_RETURN_IN[s]),
         .expired_out (card_expire[s])
      );
   end

   assign f        = CFG_REQ_IN.func;
   assign wr_retry = CFG_REQ_IN.wr && CFG_REQ_IN.addr == RETRY_STATUS_OFFSET;
   assign wr_card  = CFG_REQ_IN.wr && CFG_REQ_IN.addr == CARD_CONTROL_OFFSET;

   ////////////////////////////////////////////////////////////////////////////////
   // register writes and hardware events; a set always beats a same-cycle clear
   always_comb begin
      next_host_timer_en = host_timer_en;
      next_card_timer_en = card_timer_en;
      next_host_exp      = host_exp;
      next_card_a_exp    = card_a_exp;
      next_card_b_exp    = card_b_exp;
      next_ring_en       = ring_en;
      next_video_en      = video_en;
      next_port_sel      = port_sel;
      next_audio_en      = audio_en;
      next_spk_en        = spk_en;
      next_int_flag      = int_flag;
      next_route         = route;
      // the retry register is one shared copy, so function 1 sees the same bits
      if (wr_retry) begin
         next_host_timer_en = CFG_REQ_IN.wdata[HOST_TIMER_EN_BIT];
         next_card_timer_en = CFG_REQ_IN.wdata[CARD_TIMER_EN_BIT];
         if (CFG_REQ_IN.wdata[HOST_EXP_BIT]) next_host_exp = 1'b0;
         if (CFG_REQ_IN.wdata[CARD_A_EXP_BIT]) next_card_a_exp = 1'b0;
         if (CFG_REQ_IN.wdata[CARD_B_EXP_BIT]) next_card_b_exp = 1'b0;
      end
      if (wr_card) begin
         next_ring_en     = CFG_REQ_IN.wdata[RING_EN_BIT];
         next_video_en[f] = CFG_REQ_IN.wdata[VIDEO_EN_BIT];
         next_port_sel[f] = CFG_REQ_IN.wdata[PORT_SEL_BIT];
         next_audio_en[f] = CFG_REQ_IN.wdata[AUDIO_EN_BIT];
         next_spk_en[f]   = CFG_REQ_IN.wdata[SPK_EN_BIT];
         if (CFG_REQ_IN.wdata[INT_FLAG_BIT]) next_int_flag[f] = 1'b0;
      end
      if (CFG_REQ_IN.wr && CFG_REQ_IN.addr == PIN_ROUTE_LOW_OFFSET) begin
         next_route = CFG_REQ_IN.wdata;
      end
      if (host_expire) next_host_exp = 1'b1;
      if (card_expire[0]) next_card_a_exp = 1'b1;
      if (card_expire[1]) next_card_b_exp = 1'b1;
      next_int_flag = next_int_flag | CARD_FUNC_INT_IN;
   end

   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         host_timer_en <= HOST_TIMER_EN_RESET;
         card_timer_en <= CARD_TIMER_EN_RESET;
         host_exp      <= 1'b0;
         card_a_exp    <= 1'b0;
         card_b_exp    <= 1'b0;
         ring_en       <= 1'b0;
         video_en      <= 2'h0;
         port_sel      <= 2'h0;
         audio_en      <= 2'h0;
         spk_en        <= 2'h0;
         int_flag      <= 2'h0;
         route         <= PIN_ROUTE_RESET;
      end else if (CORE_CE_IN) begin
         host_timer_en <= next_host_timer_en;
         card_timer_en <= next_card_timer_en;
         host_exp      <= next_host_exp;
         card_a_exp    <= next_card_a_exp;
         card_b_exp    <= next_card_b_exp;
         ring_en       <= next_ring_en;
         video_en      <= next_video_en;
         port_sel      <= next_port_sel;
         audio_en      <= next_audio_en;
         spk_en        <= next_spk_en;
         int_flag      <= next_int_flag;
         route         <= next_route;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read answers and registered pin outputs
   always_comb begin
      next_rsp.valid = CFG_REQ_IN.rd;
      next_rsp.data  = CFG_DATA_RESET;
      if (CFG_REQ_IN.rd) begin
         case (CFG_REQ_IN.addr)
            RETRY_STATUS_OFFSET:
               next_rsp.data = {host_timer_en, card_timer_en, card_b_exp, 1'b0,
                                card_a_exp, 1'b0, host_exp, 1'b0};
            CARD_CONTROL_OFFSET:
               next_rsp.data = {ring_en, video_en[f], port_sel[f], 2'b00,
                                audio_en[f], spk_en[f], int_flag[f]};
            PIN_ROUTE_LOW_OFFSET:
               next_rsp.data = route;
            default:
               next_rsp.data = CFG_DATA_RESET;
         endcase
      end
      // strap is caught on the first enabled edge after reset release
      next_strap_done  = 1'b1;
      next_serial_mode = strap_done ? SERIAL_MODE_OUT : !SERIAL_LATCH_N_IN;
   end

   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         CFG_RSP_OUT               <= '0;
         strap_done                <= 1'b0;
         SERIAL_MODE_OUT           <= 1'b0;
         RING_PIN_OUT              <= 1'b0;
         RING_ROUTE_OUT            <= 1'b0;
         VIDEO_PORT_HIZ_OUT        <= 2'h0;
         VIDEO_SELECT_SOCKET0_OUT  <= 1'b0;
         VIDEO_SELECT_SOCKET1_OUT  <= 1'b0;
         AUDIO_PWM_OUTPUT_OUT      <= 1'b0;
         SPEAKER_OUTPUT_PIN_OUT    <= 1'b0;
         SPEAKER_OUTPUT_PIN_OE_OUT <= 1'b0;
         GENERAL_INPUT_0_OUT       <= 1'b0;
         MULTIPURPOSE_PIN_0_OUT    <= 1'b0;
         MULTIPURPOSE_PIN_0_OE_OUT <= 1'b0;
         MULTIPURPOSE_PIN_1_OUT    <= 1'b0;
         MULTIPURPOSE_PIN_1_OE_OUT <= 1'b0;
      end else if (CORE_CE_IN) begin
         CFG_RSP_OUT     <= next_rsp;
         strap_done      <= next_strap_done;
         SERIAL_MODE_OUT <= next_serial_mode;
         RING_PIN_OUT    <= ring_en && !RING_PIN_SELECT_IN && RING_INDICATE_OUTPUT_IN;
         RING_ROUTE_OUT  <= ring_en && RING_INDICATE_OUTPUT_IN;
         VIDEO_PORT_HIZ_OUT <= video_en;
         // port select of function 0 settles a tie between the sockets
         VIDEO_SELECT_SOCKET0_OUT <= video_en[0] && !(video_en[1] && port_sel[0]);
         VIDEO_SELECT_SOCKET1_OUT <= video_en[1] && !(video_en[0] && !port_sel[0]);
         AUDIO_PWM_OUTPUT_OUT <= audio_en[0] ? CARD_AUDIO_SIGNAL_IN[0] :
                                 audio_en[1] && CARD_AUDIO_SIGNAL_IN[1];
         SPEAKER_OUTPUT_PIN_OUT    <= ^CARD_SPEAKER_SIGNAL_IN;
         SPEAKER_OUTPUT_PIN_OE_OUT <= |spk_en;
         if (route[3:0] == ROUTE_GENERAL_INPUT) GENERAL_INPUT_0_OUT <= MULTIPURPOSE_PIN_0_IN;
         case (route[3:0])
            ROUTE_GENERAL_OUTPUT: begin
               MULTIPURPOSE_PIN_0_OUT    <= GENERAL_OUTPUT_0_IN;
               MULTIPURPOSE_PIN_0_OE_OUT <= 1'b1;
            end
            ROUTE_HOST_INT_A: begin
               MULTIPURPOSE_PIN_0_OUT    <= HOST_INTERRUPT_A_IN;
               MULTIPURPOSE_PIN_0_OE_OUT <= 1'b1;
            end
            default: begin
               MULTIPURPOSE_PIN_0_OUT    <= 1'b0;
               MULTIPURPOSE_PIN_0_OE_OUT <= 1'b0;
            end
         endcase
         // serial data is open drain: pull low or release
         MULTIPURPOSE_PIN_1_OUT    <= 1'b0;
         MULTIPURPOSE_PIN_1_OE_OUT <= SERIAL_MODE_OUT && SERIAL_DATA_LOW_IN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RSTN_IN);

   sequence s_host_clear_write;
      CORE_CE_IN && wr_retry && CFG_REQ_IN.wdata[HOST_EXP_BIT];
   endsequence

   sequence s_retry_read;
      CORE_CE_IN && CFG_REQ_IN.rd && CFG_REQ_IN.addr == RETRY_STATUS_OFFSET;
   endsequence

   a_host_exp_set: assert property (
      CORE_CE_IN && host_expire |=> host_exp)
      else $error("host expiry flag not set");

   a_w1c_clear: assert property (
      s_host_clear_write ##0 !host_expire |=> !host_exp)
      else $error("host expiry flag not cleared by one");

   a_w0_hold: assert property (
      CORE_CE_IN && host_exp && !(wr_retry && CFG_REQ_IN.wdata[HOST_EXP_BIT]) |=> host_exp)
      else $error("host expiry flag lost without clear");

   a_card_flags_set: assert property (
      CORE_CE_IN && card_expire == 2'b11 |=> card_a_exp && card_b_exp)
      else $error("card expiry flags not set");

   a_reserved_zero: assert property (
      s_retry_read |=> CFG_RSP_OUT.valid && CFG_RSP_OUT.data[4] == 1'b0
      && CFG_RSP_OUT.data[2] == 1'b0 && CFG_RSP_OUT.data[0] == 1'b0)
      else $error("reserved retry bits not zero");

   a_ring_blocked: assert property (
      CORE_CE_IN && !ring_en |=> !RING_PIN_OUT && !RING_ROUTE_OUT)
      else $error("ring output leaked while disabled");

   a_video_priority: assert property (
      CORE_CE_IN && video_en == 2'b11 |=> VIDEO_SELECT_SOCKET1_OUT == $past(port_sel[0])
      && VIDEO_SELECT_SOCKET0_OUT != VIDEO_SELECT_SOCKET1_OUT)
      else $error("video priority wrong");

   a_audio_priority: assert property (
      CORE_CE_IN && audio_en == 2'b11 |=> AUDIO_PWM_OUTPUT_OUT == $past(CARD_AUDIO_SIGNAL_IN[0]))
      else $error("socket 0 audio did not win");

   a_speaker_drive: assert property (
      CORE_CE_IN |=> SPEAKER_OUTPUT_PIN_OE_OUT == $past(|spk_en)
      && SPEAKER_OUTPUT_PIN_OUT == $past(^CARD_SPEAKER_SIGNAL_IN))
      else $error("speaker pin wrong");

   a_int_flag_set: assert property (
      CORE_CE_IN && CARD_FUNC_INT_IN[1] |=> int_flag[1] ##1 int_flag[1] || $past(wr_card))
      else $error("interrupt flag not set");

   a_global_readback: assert property (
      CORE_CE_IN && CFG_REQ_IN.rd && CFG_REQ_IN.addr == CARD_CONTROL_OFFSET
      |=> CFG_RSP_OUT.data[RING_EN_BIT] == $past(ring_en))
      else $error("global ring enable differs by function");

   a_pin0_gpo: assert property (
      CORE_CE_IN && route[3:0] == ROUTE_GENERAL_OUTPUT
      |=> MULTIPURPOSE_PIN_0_OE_OUT && MULTIPURPOSE_PIN_0_OUT == $past(GENERAL_OUTPUT_0_IN))
      else $error("pin 0 general output wrong");

   a_serial_pin1: assert property (
      CORE_CE_IN && !SERIAL_MODE_OUT |=> !MULTIPURPOSE_PIN_1_OE_OUT)
      else $error("pin 1 driven outside serial mode");

endmodule

/* retry_master_model.sv */
// model of the host and card masters that the bridge retries
`timescale 1ns/1ps
module retry_master_model (
   input  wire logic  clk_in,
   output logic       host_retry_out,
   output logic       host_return_out,
   output logic [1:0] card_retry_out,
   output logic [1:0] card_return_out
);
   initial begin
      host_retry_out = 1'b0;
      host_return_out = 1'b0;
      card_retry_out = 2'b00;
      card_return_out = 2'b00;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // side: bit 0 host, bit 1 card A, bit 2 card B; a negative wait never comes back
   // call just after a rising edge; a slow master is simply a long wait
   task automatic retried(input logic [2:0] side, input int wait_n);
      host_retry_out = side[0];
      card_retry_out = side[2:1];
      @(posedge clk_in);
      #1;
      host_retry_out = 1'b0;
      card_retry_out = 2'b00;
      if (wait_n >= 0) begin
         repeat (wait_n) @(posedge clk_in);
         #1;
         host_return_out = side[0];
         card_return_out = side[2:1];
         @(posedge clk_in);
         #1;
         host_return_out = 1'b0;
         card_return_out = 2'b00;
         @(posedge clk_in);
         #1;
      end
   endtask
endmodule

/* testbench.sv */
// self-checking bench for the retry status, card control and pin routing block
`timescale 1ns/1ps
module testbench;
   import retry_card_pkg::*;
   localparam int unsigned LIM = 8;
   logic clk = 1'b0, rstn = 1'b0, h_rty, h_ret, ring = 1'b0, ring_sel = 1'b0;
   logic gpo = 1'b0, host_int = 1'b0, pin0_in = 1'b0, latch_n = 1'b0, sda_low = 1'b0;
   logic ring_pin, ring_route, vsel0, vsel1, pwm, spk_out, spk_oe, gpi, pin0_out;
   logic pin0_oe, pin1_out, pin1_oe, ser_mode, ce = 1'b1;
   logic [1:0] c_rty, c_ret, hiz, func_int = 2'b00, aud = 2'b00, spk = 2'b00;
   logic [7:0] d0, d1;
   cfg_req_t   req = '0;
   cfg_rsp_t   rsp;
   int         n_fail = 0, checks_done = 0, seed = 38740;

   retry_master_model rm (.clk_in(clk), .host_retry_out(h_rty), .host_return_out(h_ret),
      .card_retry_out(c_rty), .card_return_out(c_ret));
   retry_card_control #(.RETRY_LIMIT(LIM)) dut (.CORE_CLK_IN(clk), .RSTN_IN(rstn),
      .CORE_CE_IN(ce), .CFG_REQ_IN(req), .CFG_RSP_OUT(rsp), .HOST_RETRY_IN(h_rty),
      .HOST_RETURN_IN(h_ret), .CARD_RETRY_IN(c_rty), .CARD_RETURN_IN(c_ret),
      .CARD_FUNC_INT_IN(func_int), .RING_INDICATE_OUTPUT_IN(ring),
      .RING_PIN_SELECT_IN(ring_sel), .RING_PIN_OUT(ring_pin), .RING_ROUTE_OUT(ring_route),
      .VIDEO_PORT_HIZ_OUT(hiz), .VIDEO_SELECT_SOCKET0_OUT(vsel0),
      .VIDEO_SELECT_SOCKET1_OUT(vsel1), .CARD_AUDIO_SIGNAL_IN(aud),
      .AUDIO_PWM_OUTPUT_OUT(pwm), .CARD_SPEAKER_SIGNAL_IN(spk),
      .SPEAKER_OUTPUT_PIN_OUT(spk_out), .SPEAKER_OUTPUT_PIN_OE_OUT(spk_oe),
      .GENERAL_OUTPUT_0_IN(gpo), .HOST_INTERRUPT_A_IN(host_int), .GENERAL_INPUT_0_OUT(gpi),
      .MULTIPURPOSE_PIN_0_IN(pin0_in), .MULTIPURPOSE_PIN_0_OUT(pin0_out),
      .MULTIPURPOSE_PIN_0_OE_OUT(pin0_oe), .SERIAL_LATCH_N_IN(latch_n),
      .SERIAL_DATA_LOW_IN(sda_low), .MULTIPURPOSE_PIN_1_OUT(pin1_out),
      .MULTIPURPOSE_PIN_1_OE_OUT(pin1_oe), .SERIAL_MODE_OUT(ser_mode));

   initial begin
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one idle cycle after each access keeps the strobes from being re-driven in one step
   task automatic cfg_wr(input logic f, input logic [7:0] a, input logic [7:0] d);
      req = '{wr: 1'b1, rd: 1'b0, func: f, addr: a, wdata: d};
      tick;
      req = '0;
      tick;
   endtask
   task automatic cfg_rd(input logic f, input logic [7:0] a, input logic [7:0] exp,
                         input string name);
      req = '{wr: 1'b0, rd: 1'b1, func: f, addr: a, wdata: 8'h00};
      tick;
      req = '0;
      check({name, " valid"}, {7'h00, rsp.valid}, 8'h01);
      check(name, rsp.data, exp);
      tick;
   endtask
   function automatic logic audio_exp(input logic [7:0] a, input logic [1:0] s);
      return a[2] ? s[0] : s[1];
   endfunction
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      summarize();
   end

   initial begin
      repeat (5) @(posedge clk);
      #1;
      rstn = 1'b1;
      cfg_rd(1'b0, RETRY_STATUS_OFFSET, 8'hC0, "retry reset");
      cfg_rd(1'b1, CARD_CONTROL_OFFSET, 8'h00, "card reset");
      cfg_rd(1'b0, PIN_ROUTE_LOW_OFFSET, PIN_ROUTE_RESET, "route reset");
      cfg_rd(1'b0, 8'h95, 8'h00, "unmapped");
      check("serial mode", {7'h00, ser_mode}, 8'h01);
      $display("test reset done");
      // flag must appear exactly after the wait, not one read earlier
      rm.retried(3'b001, -1);
      repeat (LIM) tick;
      cfg_rd(1'b0, RETRY_STATUS_OFFSET, 8'hC0, "host early");
      cfg_rd(1'b0, RETRY_STATUS_OFFSET, 8'hC2, "host expired");
      cfg_wr(1'b0, RETRY_STATUS_OFFSET, 8'hC0);
      cfg_rd(1'b0, RETRY_STATUS_OFFSET, 8'hC2, "host kept");
      cfg_wr(1'b0, RETRY_STATUS_OFFSET, 8'hC2);
      cfg_rd(1'b0, RETRY_STATUS_OFFSET, 8'hC0, "host cleared");
      rm.retried(3'b110, -1);
      repeat (LIM + 4) tick;
      cfg_rd(1'b0, RETRY_STATUS_OFFSET, 8'hE8, "card expired");
      cfg_wr(1'b0, RETRY_STATUS_OFFSET, 8'hE8);
      cfg_rd(1'b0, RETRY_STATUS_OFFSET, 8'hC0, "card cleared");
      rm.retried(3'b111, 3);
      repeat (LIM + 4) tick;
      cfg_rd(1'b0, RETRY_STATUS_OFFSET, 8'hC0, "returned");
      cfg_wr(1'b0, RETRY_STATUS_OFFSET, 8'h00);
      rm.retried(3'b111, -1);
      repeat (LIM + 4) tick;
      cfg_rd(1'b0, RETRY_STATUS_OFFSET, 8'h00, "disabled");
      cfg_wr(1'b0, RETRY_STATUS_OFFSET, 8'hC0);
      $display("test retry done");
      func_int = 2'b10;
      tick;
      func_int = 2'b00;
      cfg_rd(1'b1, CARD_CONTROL_OFFSET, 8'h01, "flag B");
      cfg_rd(1'b0, CARD_CONTROL_OFFSET, 8'h00, "flag A");
      cfg_wr(1'b1, CARD_CONTROL_OFFSET, 8'h00);
      cfg_rd(1'b1, CARD_CONTROL_OFFSET, 8'h01, "flag kept");
      cfg_wr(1'b1, CARD_CONTROL_OFFSET, 8'h01);
      cfg_rd(1'b1, CARD_CONTROL_OFFSET, 8'h00, "flag cleared");
      $display("test flag done");
      for (int i = 0; i < 4; i++) begin
         cfg_wr(1'b0, CARD_CONTROL_OFFSET, {i[1], 7'h00});
         ring = 1'b1;
         ring_sel = i[0];
         tick;
         check("ring pin", {7'h00, ring_pin}, {7'h00, i[1] & ~i[0]});
         check("ring route", {7'h00, ring_route}, {7'h00, i[1]});
         cfg_rd(1'b1, CARD_CONTROL_OFFSET, {i[1], 7'h00}, "ring global");
      end
      $display("test ring done");
      for (int n = 0; n < 12; n++) begin
         d0 = n == 0 ? 8'h66 : 8'($random(seed)) & 8'h66;
         d1 = n == 0 ? 8'h66 : 8'($random(seed)) & 8'h66;
         aud = 2'($random(seed));
         spk = 2'($random(seed));
         cfg_wr(1'b0, CARD_CONTROL_OFFSET, d0);
         cfg_wr(1'b1, CARD_CONTROL_OFFSET, d1);
         cfg_rd(1'b0, CARD_CONTROL_OFFSET, d0, "card A");
         cfg_rd(1'b1, CARD_CONTROL_OFFSET, d1, "card B");
         check("video hiz", {6'h00, hiz}, {6'h00, d1[6], d0[6]});
         check("spk oe", {7'h00, spk_oe}, {7'h00, d0[1] | d1[1]});
         if (d0[1] | d1[1])
            check("spk", {7'h00, spk_out}, {7'h00, spk[0] ^ spk[1]});
         if (d0[2] | d1[2])
            check("pwm", {7'h00, pwm}, {7'h00, audio_exp(d0, aud)});
         if (d0[6] & d1[6])
            check("video sel", {6'h00, vsel1, vsel0}, {6'h00, d0[5], ~d0[5]});
      end
      $display("test card done");
      for (int c = 0; c < 4; c++) begin
         cfg_wr(1'b0, PIN_ROUTE_LOW_OFFSET, 8'(c));
         cfg_rd(1'b0, PIN_ROUTE_LOW_OFFSET, 8'(c), "route");
         for (int v = 0; v < 2; v++) begin
            gpo = v[0];
            host_int = ~v[0];
            pin0_in = v[0];
            tick;
            tick;
            check("pin0 oe", {7'h00, pin0_oe}, {7'h00, c == 1 || c == 2});
            if (c == 1 || c == 2)
               check("pin0", {7'h00, pin0_out}, {7'h00, c == 1 ? v[0] : ~v[0]});
            else
               check("gpi", {7'h00, gpi}, {7'h00, c == 0 ? v[0] : 1'b1});
         end
      end
      ce = 1'b0;
      sda_low = 1'b1;
      tick;
      check("sda frozen", {7'h00, pin1_oe}, 8'h00);
      ce = 1'b1;
      tick;
      check("sda oe", {7'h00, pin1_oe}, 8'h01);
      check("sda out", {7'h00, pin1_out}, 8'h00);
      sda_low = 1'b0;
      tick;
      check("sda release", {7'h00, pin1_oe}, 8'h00);
      cfg_wr(1'b0, RETRY_STATUS_OFFSET, 8'h00);
      latch_n = 1'b1;
      rstn = 1'b0;
      tick;
      rstn = 1'b1;
      cfg_rd(1'b0, RETRY_STATUS_OFFSET, 8'hC0, "retry rearm");
      sda_low = 1'b1;
      tick;
      check("serial off", {7'h00, ser_mode}, 8'h00);
      check("sda idle", {7'h00, pin1_oe}, 8'h00);
      $display("test pins done");
      summarize();
   end
endmodule
